// ==== sdpc_pkg.sv ====
// Shared constants and types for the stepper driver control block
package sdpc_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int SDPC_ADDR_W = 8;
    localparam int SDPC_DATA_W = 32;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SDPC_CTRL_OFS     = 8'h00;
    localparam logic [7:0] SDPC_STATUS_OFS   = 8'h04;
    localparam logic [7:0] SDPC_PHASE_OFS    = 8'h08;
    localparam logic [7:0] SDPC_IRQ_STAT_OFS = 8'h0c;
    localparam logic [7:0] SDPC_IRQ_MASK_OFS = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SDPC_CTRL_SOFT_STANDBY_N = 0;

    localparam int SDPC_ST_SERIAL      = 0;
    localparam int SDPC_ST_MOTOR_GOOD  = 1;
    localparam int SDPC_ST_LOGIC_GOOD  = 2;
    localparam int SDPC_ST_OC_LATCH    = 3;
    localparam int SDPC_ST_OT_LATCH    = 4;
    localparam int SDPC_ST_STANDBY     = 5;
    localparam int SDPC_ST_DRIVE_EN    = 6;

    localparam int SDPC_IRQ_W          = 3;
    localparam int SDPC_IRQ_OC         = 0;
    localparam int SDPC_IRQ_OT         = 1;
    localparam int SDPC_IRQ_SUPPLY     = 2;

    // Synchroniser lane positions
    localparam int SDPC_SYNC_W         = 13;
    localparam int SDPC_LN_THERMAL     = 0;
    localparam int SDPC_LN_OVERCUR     = 1;
    localparam int SDPC_LN_LOGIC_GOOD  = 2;
    localparam int SDPC_LN_MOTOR_GOOD  = 3;
    localparam int SDPC_LN_PHASE_LO    = 4;
    localparam int SDPC_LN_MODE        = 12;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic                  SDPC_CTRL_RST  = 1'b0;
    localparam logic [SDPC_IRQ_W-1:0] SDPC_MASK_RST  = 3'h0;
    localparam logic [SDPC_IRQ_W-1:0] SDPC_STAT_RST  = 3'h0;
    localparam logic [7:0]            SDPC_PHASE_RST = 8'h00;
    localparam logic [31:0]           SDPC_RDATA_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {SDPC_PARALLEL, SDPC_SERIAL} sdpc_mode_t;

    typedef struct packed {
        logic a_plus;
        logic a_minus;
        logic b_plus;
        logic b_minus;
        logic c_plus;
        logic c_minus;
        logic d_plus;
        logic d_minus;
    } sdpc_phase_t;

    typedef struct packed {
        logic data;
        logic clk;
        logic storage_clear_n;
        logic gate;
        logic latch;
        logic standby_n;
    } sdpc_serial_t;

    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [SDPC_ADDR_W-1:0] addr;
        logic [SDPC_DATA_W-1:0] wdata;
    } sdpc_bus_req_t;

endpackage : sdpc_pkg

// ==== sdpc_sync.sv ====
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none
module sdpc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    import sdpc_pkg::*;

    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] stable_reg;
    logic [W-1:0] stable_next;

    always_comb begin
        meta_next   = async_in;
        stable_next = meta_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            meta_reg   <= '0;
            stable_reg <= '0;
        end else begin
            meta_reg   <= meta_next;
            stable_reg <= stable_next;
        end
    end

    assign sync_out = stable_reg;

endmodule : sdpc_sync
`default_nettype wire

// ==== sdpc_top.sv ====
// Stepper driver control: interface select, phase drive, fault latches
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Interface-select low picks direct parallel drive, high picks serial conversion.
// - In parallel mode each phase input turns its own transistor on while high, plus then minus.
// - Over-current switches the outputs off until supply re-application or standby.
// - Over-temperature switches all outputs off, cleared only by supply re-application or standby.
// - The motor-supply status reads high above threshold and low below it.
// - Transistors are enabled only while motor and logic supply monitors are both high.
// - The open-drain fault flag pulls low while either shutdown latch is active.
// - In normal operation the fault flag releases its pin.
// - Once the latched fault clears, the fault flag releases again.
// - In serial mode the input pins become serial data, clock, latch, clear, gate, standby and alarm.
// - Standby low turns off all functions and outputs and clears latched faults; here the phase outputs are forced off and the fault latches cleared.
module sdpc_top (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // Register port
    input  wire sdpc_pkg::sdpc_bus_req_t bus_req,
    output logic [31:0]               rd_data,
    output logic                      irq,
    // Interface select and logic pins
    input  wire logic                 mode_pin,
    input  wire sdpc_pkg::sdpc_phase_t phase_in,
    output logic                      thermal_alarm_n_o,
    output logic                      thermal_alarm_n_oe_n,
    // Supply monitors and detectors
    input  wire logic                 motor_supply_good,
    input  wire logic                 logic_supply_good,
    input  wire logic                 overcurrent_detect,
    input  wire logic                 thermal_shutdown,
    // Serial engine link
    output sdpc_pkg::sdpc_serial_t    serial_pins,
    input  wire sdpc_pkg::sdpc_phase_t serial_enable,
    input  wire logic                 serial_alarm,
    // Motor outputs and fault flag
    output sdpc_pkg::sdpc_phase_t     phase_out,
    output logic                      fault_flag_o,
    output logic                      fault_flag_oe_n
);
    import sdpc_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [SDPC_SYNC_W-1:0] raw_pins;
    logic [SDPC_SYNC_W-1:0] sync_pins;

    assign raw_pins = {mode_pin, phase_in, motor_supply_good, logic_supply_good,
                       overcurrent_detect, thermal_shutdown};

    sdpc_sync #(
        .W (SDPC_SYNC_W)
    ) sdpc_sync_inst (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (raw_pins),
        .sync_out (sync_pins)
    );

    // ------------------------------------------------------------
    // Decoded pin levels
    // ------------------------------------------------------------
    sdpc_mode_t  mode;
    sdpc_phase_t phase_s;
    logic        motor_good;
    logic        logic_good;
    logic        oc_det;
    logic        ot_det;
    sdpc_serial_t serial_s;

    always_comb begin
        mode       = sync_pins[SDPC_LN_MODE] ? SDPC_SERIAL : SDPC_PARALLEL;
        phase_s    = sdpc_phase_t'(sync_pins[SDPC_LN_PHASE_LO +: 8]);
        motor_good = sync_pins[SDPC_LN_MOTOR_GOOD];
        logic_good = sync_pins[SDPC_LN_LOGIC_GOOD];
        oc_det     = sync_pins[SDPC_LN_OVERCUR];
        ot_det     = sync_pins[SDPC_LN_THERMAL];
        // Pin reuse in serial mode
        serial_s.data            = phase_s.d_plus;
        serial_s.clk             = phase_s.d_minus;
        serial_s.storage_clear_n = phase_s.a_plus;
        serial_s.gate            = phase_s.a_minus;
        serial_s.standby_n       = phase_s.b_plus;
        serial_s.latch           = phase_s.b_minus;
    end

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic                  soft_standby_n_reg, soft_standby_n_next;
    logic [SDPC_IRQ_W-1:0] mask_reg, mask_next;
    logic [SDPC_IRQ_W-1:0] stat_reg, stat_next;
    logic                  oc_latch_reg, oc_latch_next;
    logic                  ot_latch_reg, ot_latch_next;
    logic                  motor_prev_reg, motor_prev_next;
    sdpc_phase_t           phase_out_reg, phase_out_next;
    sdpc_serial_t          serial_reg, serial_next;
    logic                  fault_oe_n_reg, fault_oe_n_next;
    logic                  alarm_oe_n_reg, alarm_oe_n_next;
    logic                  irq_reg, irq_next;
    logic [31:0]           rd_data_reg, rd_data_next;

    logic                  standby_act;
    logic                  clear_latch;
    logic                  fault_any;
    logic                  drive_en;
    logic [SDPC_IRQ_W-1:0] events;
    logic [SDPC_IRQ_W-1:0] w1c;
    logic [31:0]           status_word;

    // ------------------------------------------------------------
    // Fault latches and drive gate
    // ------------------------------------------------------------
    always_comb begin
        standby_act = soft_standby_n_reg
                    | ((mode == SDPC_SERIAL) & ~serial_s.standby_n);
        // Supply low means a later re-application starts clean
        clear_latch = standby_act | ~motor_good;
        // Detection wins over a clear in the same cycle
        oc_latch_next = oc_det | (oc_latch_reg & ~clear_latch);
        ot_latch_next = ot_det | (ot_latch_reg & ~clear_latch);
        fault_any     = oc_latch_reg | ot_latch_reg;
        drive_en      = motor_good & logic_good & ~fault_any & ~standby_act;
        motor_prev_next = motor_good;

        phase_out_next = SDPC_PHASE_RST;
        if (drive_en) begin
            case (mode)
                SDPC_PARALLEL: phase_out_next = phase_s;
                SDPC_SERIAL:   phase_out_next = serial_enable;
                default:       phase_out_next = SDPC_PHASE_RST;
            endcase
        end

        // Open drain: low enable means the pin is pulled to ground
        fault_oe_n_next = ~(oc_latch_next | ot_latch_next);

        serial_next     = (mode == SDPC_SERIAL) ? serial_s : '0;
        serial_next.standby_n = (mode == SDPC_SERIAL) ? serial_s.standby_n : 1'b0;
        alarm_oe_n_next = ~((mode == SDPC_SERIAL) & serial_alarm);
    end

    // ------------------------------------------------------------
    // Register port and interrupts
    // ------------------------------------------------------------
    always_comb begin
        events = '0;
        events[SDPC_IRQ_OC]     = oc_latch_next & ~oc_latch_reg;
        events[SDPC_IRQ_OT]     = ot_latch_next & ~ot_latch_reg;
        events[SDPC_IRQ_SUPPLY] = motor_prev_reg & ~motor_good;

        soft_standby_n_next = soft_standby_n_reg;
        mask_next      = mask_reg;
        w1c            = '0;
        if (bus_req.wr) begin
            case (bus_req.addr)
                SDPC_CTRL_OFS:     soft_standby_n_next = bus_req.wdata[SDPC_CTRL_SOFT_STANDBY_N];
                SDPC_IRQ_MASK_OFS: mask_next      = bus_req.wdata[SDPC_IRQ_W-1:0];
                SDPC_IRQ_STAT_OFS: w1c            = bus_req.wdata[SDPC_IRQ_W-1:0];
                default:           w1c            = '0;
            endcase
        end
        // A new event beats a clear in the same cycle
        stat_next = (stat_reg & ~w1c) | events;
        irq_next  = |(stat_next & mask_next);

        status_word = '0;
        status_word[SDPC_ST_SERIAL]     = (mode == SDPC_SERIAL);
        status_word[SDPC_ST_MOTOR_GOOD] = motor_good;
        status_word[SDPC_ST_LOGIC_GOOD] = logic_good;
        status_word[SDPC_ST_OC_LATCH]   = oc_latch_reg;
        status_word[SDPC_ST_OT_LATCH]   = ot_latch_reg;
        status_word[SDPC_ST_STANDBY]    = standby_act;
        status_word[SDPC_ST_DRIVE_EN]   = drive_en;

        rd_data_next = SDPC_RDATA_RST;
        if (bus_req.rd) begin
            case (bus_req.addr)
                SDPC_CTRL_OFS:     rd_data_next = {31'h0, soft_standby_n_reg};
                SDPC_STATUS_OFS:   rd_data_next = status_word;
                SDPC_PHASE_OFS:    rd_data_next = {24'h0, phase_out_reg};
                SDPC_IRQ_STAT_OFS: rd_data_next = {29'h0, stat_reg};
                SDPC_IRQ_MASK_OFS: rd_data_next = {29'h0, mask_reg};
                default:           rd_data_next = SDPC_RDATA_RST;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            soft_standby_n_reg  <= SDPC_CTRL_RST;
            mask_reg       <= SDPC_MASK_RST;
            stat_reg       <= SDPC_STAT_RST;
            oc_latch_reg   <= 1'b0;
            ot_latch_reg   <= 1'b0;
            motor_prev_reg <= 1'b0;
            phase_out_reg  <= SDPC_PHASE_RST;
            serial_reg     <= '0;
            fault_oe_n_reg <= 1'b1;
            alarm_oe_n_reg <= 1'b1;
            irq_reg        <= 1'b0;
            rd_data_reg    <= SDPC_RDATA_RST;
        end else begin
            soft_standby_n_reg  <= soft_standby_n_next;
            mask_reg       <= mask_next;
            stat_reg       <= stat_next;
            oc_latch_reg   <= oc_latch_next;
            ot_latch_reg   <= ot_latch_next;
            motor_prev_reg <= motor_prev_next;
            phase_out_reg  <= phase_out_next;
            serial_reg     <= serial_next;
            fault_oe_n_reg <= fault_oe_n_next;
            alarm_oe_n_reg <= alarm_oe_n_next;
            irq_reg        <= irq_next;
            rd_data_reg    <= rd_data_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign phase_out            = phase_out_reg;
    assign serial_pins          = serial_reg;
    assign fault_flag_o         = 1'b0;
    assign fault_flag_oe_n      = fault_oe_n_reg;
    assign thermal_alarm_n_o    = 1'b0;
    assign thermal_alarm_n_oe_n = alarm_oe_n_reg;
    assign irq                  = irq_reg;
    assign rd_data              = rd_data_reg;

endmodule : sdpc_top
`default_nettype wire

// ==== sdpc_monitor.sv ====
// Port checker for the stepper driver control block
`timescale 1ns/1ns
`default_nettype none
module sdpc_monitor
    import sdpc_pkg::*;
(
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst,
    // Pins and monitors
    input wire logic                  mode_pin,
    input wire sdpc_pkg::sdpc_phase_t phase_in,
    input wire logic                  motor_supply_good,
    input wire logic                  logic_supply_good,
    input wire logic                  overcurrent_detect,
    input wire logic                  thermal_shutdown,
    // Outputs
    input wire sdpc_pkg::sdpc_serial_t serial_pins,
    input wire logic                  thermal_alarm_n_oe_n,
    input wire sdpc_pkg::sdpc_phase_t phase_out,
    input wire logic                  fault_flag_o,
    input wire logic                  fault_flag_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence par_ok4;
        (!mode_pin && motor_supply_good && logic_supply_good
         && !overcurrent_detect && !thermal_shutdown)[*4];
    endsequence
    sequence bad_supply4;
        (!(motor_supply_good && logic_supply_good))[*4];
    endsequence
    sequence clear4;
        (!motor_supply_good && !overcurrent_detect && !thermal_shutdown)[*4];
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    par_drive_a: assert property (par_ok4 ##0 (phase_out != '0 && fault_flag_oe_n)
        |-> phase_out == $past(phase_in, 3)) else $error("phase out differs from pins");
    supply_gate_a: assert property (bad_supply4 |-> phase_out == '0)
        else $error("outputs on with a bad supply");
    oc_off_a: assert property (overcurrent_detect[*5]
        |-> !fault_flag_oe_n && phase_out == '0) else $error("overcurrent not shut off");
    ot_off_a: assert property (thermal_shutdown[*5]
        |-> !fault_flag_oe_n && phase_out == '0) else $error("overheat not shut off");
    flag_release_a: assert property (clear4 |-> fault_flag_oe_n)
        else $error("fault flag held after clear");
    flag_drive_a: assert property (fault_flag_o == 1'b0)
        else $error("fault flag drives high");
    flag_cause_a: assert property ($fell(fault_flag_oe_n)
        |-> $past(overcurrent_detect, 3) || $past(thermal_shutdown, 3))
        else $error("fault flag fell with no detector");
    serial_quiet_a: assert property ((!mode_pin)[*4]
        |-> serial_pins == '0 && thermal_alarm_n_oe_n) else $error("serial pins live in parallel");
    serial_route_a: assert property (mode_pin[*5] |->
        serial_pins.data == $past(phase_in.d_plus, 3)
        && serial_pins.clk == $past(phase_in.d_minus, 3)
        && serial_pins.standby_n == $past(phase_in.b_plus, 3)) else $error("serial pin routing");
endmodule : sdpc_monitor

bind sdpc_top sdpc_monitor sdpc_monitor_inst (.sys_clk(sys_clk), .rst(rst),
    .mode_pin(mode_pin), .phase_in(phase_in), .motor_supply_good(motor_supply_good),
    .logic_supply_good(logic_supply_good), .overcurrent_detect(overcurrent_detect),
    .thermal_shutdown(thermal_shutdown), .serial_pins(serial_pins),
    .thermal_alarm_n_oe_n(thermal_alarm_n_oe_n), .phase_out(phase_out),
    .fault_flag_o(fault_flag_o), .fault_flag_oe_n(fault_flag_oe_n));
`default_nettype wire

// ==== sdpc_host_model.sv ====
// Host controller model driving the logic input pins
`timescale 1ns/1ns
`default_nettype none
module sdpc_host_model
    import sdpc_pkg::*;
(
    // Commands from the bench
    input  wire logic                   serial_sel,
    input  wire sdpc_pkg::sdpc_phase_t  par_cmd,
    input  wire sdpc_pkg::sdpc_serial_t ser_cmd,
    input  wire logic                   alarm_oe_n,
    // Pins
    output logic                        mode_pin,
    output sdpc_pkg::sdpc_phase_t       phase_in
);
    always_comb begin
        mode_pin = serial_sel;
        phase_in = par_cmd;
        if (serial_sel) begin
            phase_in.d_plus  = ser_cmd.data;
            phase_in.d_minus = ser_cmd.clk;
            phase_in.a_plus  = ser_cmd.storage_clear_n;
            phase_in.a_minus = ser_cmd.gate;
            phase_in.b_plus  = ser_cmd.standby_n;
            phase_in.b_minus = ser_cmd.latch;
            // Alarm pin released by host, pulled up unless device pulls low
            phase_in.c_plus  = alarm_oe_n;
            phase_in.c_minus = 1'b0;
        end
    end
endmodule : sdpc_host_model
`default_nettype wire

// ==== sdpc_top_test.sv ====
// Self-checking testbench for the stepper driver control block
`timescale 1ns/1ns
`default_nettype none
module sdpc_top_test;
    import sdpc_pkg::*;
    logic          sys_clk = 1'b0;
    logic          rst = 1'b1;
    sdpc_bus_req_t bus_req = '0;
    logic [31:0]   rd_data;
    logic          irq, mode_pin, alarm_o, alarm_oe_n, fault_o, fault_oe_n;
    logic          serial_sel = 1'b0, ser_alarm = 1'b0;
    logic          motor_good = 1'b1, logic_good = 1'b1, det_oc = 1'b0, det_ot = 1'b0;
    sdpc_phase_t   par_cmd = '0, ser_en = '0, phase_in, phase_out;
    sdpc_serial_t  ser_cmd = '0, serial_pins;
    wire logic     fault_pin = fault_oe_n ? 1'b1 : fault_o;
    wire logic     alarm_pin = alarm_oe_n ? 1'b1 : alarm_o;
    int            error_cnt = 0, num_checks = 0;

    always #25 sys_clk = ~sys_clk;

    sdpc_top sdpc_top_inst (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
        .irq(irq), .mode_pin(mode_pin), .phase_in(phase_in), .thermal_alarm_n_o(alarm_o),
        .thermal_alarm_n_oe_n(alarm_oe_n), .motor_supply_good(motor_good),
        .logic_supply_good(logic_good), .overcurrent_detect(det_oc), .thermal_shutdown(det_ot),
        .serial_pins(serial_pins), .serial_enable(ser_en), .serial_alarm(ser_alarm),
        .phase_out(phase_out), .fault_flag_o(fault_o), .fault_flag_oe_n(fault_oe_n));
    sdpc_host_model sdpc_host_model_inst (.serial_sel(serial_sel), .par_cmd(par_cmd),
        .ser_cmd(ser_cmd), .alarm_oe_n(alarm_pin), .mode_pin(mode_pin), .phase_in(phase_in));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1 chk(rd_data, exp);
        @(posedge sys_clk);
    endtask : rd
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task fault_case(input int w);
        wr(SDPC_IRQ_MASK_OFS, 32'h7);
        if (w == 0) det_oc <= 1'b1; else det_ot <= 1'b1;
        idle(5);
        det_oc <= 1'b0;
        det_ot <= 1'b0;
        idle(4);
        chk(fault_pin, 1'h0);
        chk(phase_out, 8'h00);
        chk(irq, 1'h1);
        rd(SDPC_STATUS_OFS, 32'h6 | (32'h1 << (3 + w)));
        if (w == 0) begin
            wr(SDPC_CTRL_OFS, 32'h1);
            idle(4);
            rd(SDPC_STATUS_OFS, 32'h26);
            chk(phase_out, 8'h00);
            wr(SDPC_CTRL_OFS, 32'h0);
        end else begin
            motor_good <= 1'b0;
            idle(5);
            rd(SDPC_STATUS_OFS, 32'h4);
            motor_good <= 1'b1;
        end
        idle(5);
        chk(fault_pin, 1'h1);
        chk(phase_out, 8'h5a);
        rd(SDPC_IRQ_STAT_OFS, (w == 0) ? 32'h1 : 32'h6);
        wr(SDPC_IRQ_STAT_OFS, 32'h7);
        idle(2);
        chk(irq, 1'h0);
        $display("fault case %0d done", w);
    endtask : fault_case

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        idle(8);
        rst <= 1'b0;
        idle(4);
        rd(SDPC_CTRL_OFS, 32'h0);
        rd(SDPC_IRQ_MASK_OFS, 32'h0);
        rd(SDPC_IRQ_STAT_OFS, 32'h0);
        rd(8'h14, 32'h0);
        rd(SDPC_STATUS_OFS, 32'h46);
        wr(SDPC_IRQ_MASK_OFS, 32'h5);
        wr(8'h14, 32'h7);
        rd(SDPC_IRQ_MASK_OFS, 32'h5);
        wr(SDPC_IRQ_MASK_OFS, 32'h0);
        $display("registers done");
        for (int i = 0; i < 8; i++) begin
            par_cmd <= sdpc_phase_t'(8'h01 << i);
            idle(4);
            chk(phase_out, 32'h1 << i);
            rd(SDPC_PHASE_OFS, 32'h1 << i);
        end
        par_cmd <= 8'h5a;
        logic_good <= 1'b0;
        idle(5);
        chk(phase_out, 8'h00);
        logic_good <= 1'b1;
        motor_good <= 1'b0;
        idle(5);
        chk(phase_out, 8'h00);
        chk(irq, 1'h0);
        motor_good <= 1'b1;
        idle(5);
        chk(phase_out, 8'h5a);
        rd(SDPC_IRQ_STAT_OFS, 32'h4);
        wr(SDPC_IRQ_STAT_OFS, 32'h4);
        rd(SDPC_IRQ_STAT_OFS, 32'h0);
        $display("supply gate done");
        fault_case(0);
        fault_case(1);
        serial_sel <= 1'b1;
        ser_cmd <= 6'h2d;
        ser_en <= 8'h81;
        idle(5);
        chk(serial_pins, 6'h2d);
        chk(phase_out, 8'h81);
        rd(SDPC_STATUS_OFS, 32'h47);
        ser_alarm <= 1'b1;
        idle(2);
        chk(alarm_oe_n, 1'h0);
        chk(alarm_pin, 1'h0);
        ser_cmd <= 6'h2c;
        idle(5);
        chk(phase_out, 8'h00);
        ser_alarm <= 1'b0;
        serial_sel <= 1'b0;
        idle(5);
        chk(serial_pins, 6'h00);
        chk(alarm_oe_n, 1'h1);
        chk(alarm_pin, 1'h1);
        chk(phase_out, 8'h5a);
        $display("serial mode done");
        test_done;
    end

    initial begin
        #(50 * 3000);
        error_cnt++;
        test_done;
    end
endmodule : sdpc_top_test
`default_nettype wire
